// ### design/shs_pkg.sv
package shs_pkg;
  // object indices and subindices seen on the link
  localparam logic [15:0] OBJ_CONTROL_WORD = 16'h6040;
  localparam logic [15:0] OBJ_STATUS_WORD = 16'h6041;
  localparam logic [15:0] OBJ_MODE_SELECT = 16'h6060;
  localparam logic [15:0] OBJ_MODE_DISPLAY = 16'h6061;
  localparam logic [15:0] OBJ_HOMING_METHOD = 16'h6098;
  localparam logic [15:0] OBJ_HOMING_SPEED = 16'h6099;
  localparam logic [15:0] OBJ_HOMING_ACCEL = 16'h609a;
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_SPEED_SEARCH = 8'h01;
  localparam logic [7:0] SUB_SPEED_APPROACH = 8'h02;

  localparam logic [7:0] MODE_HOMING = 8'h06;

  // control word fields
  localparam int CW_START_BIT = 4;
  localparam logic [15:0] CW_ENABLE_MASK = 16'h000f;
  localparam logic [15:0] CW_ENABLE_VALUE = 16'h000f;
  localparam logic [15:0] CW_START_VALUE = 16'h001f;

  // status word fields
  localparam int SW_ENABLED_BIT = 2;
  localparam int SW_REACHED_BIT = 10;
  localparam int SW_ATTAINED_BIT = 12;
  localparam int SW_ERROR_BIT = 13;

  // homing methods
  localparam logic [7:0] METHOD_INDEX_FIRST = 8'h01;
  localparam logic [7:0] METHOD_INDEX_LAST = 8'h0e;
  localparam logic [7:0] METHOD_LIMIT_NEG = 8'h11;
  localparam logic [7:0] METHOD_LIMIT_POS = 8'h12;
  localparam logic [7:0] METHOD_HOMESW_FIRST = 8'h13;
  localparam logic [7:0] METHOD_HOMESW_LAST = 8'h1e;
  localparam logic [7:0] METHOD_INDEX_NEG = 8'h21;
  localparam logic [7:0] METHOD_INDEX_POS = 8'h22;
  localparam logic [7:0] METHOD_HERE_A = 8'h23;
  localparam logic [7:0] METHOD_HERE_B = 8'h25;
  localparam logic [7:0] METHOD_BASE_OFFSET = 8'h10;
  localparam logic [7:0] BASE_REVERSE_FIRST = 8'h07;
  localparam logic [7:0] BASE_LIMIT_LAST = 8'h02;

  // reset values
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] METHOD_RESET = 8'h00;
  localparam logic [31:0] SPEED_RESET = 32'h0000_0000;
  localparam logic [31:0] ACCEL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {DEV_IDLE, DEV_SEARCH, DEV_APPROACH} shs_dev_state_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_REQ, HOST_WAIT} shs_host_state_t;
endpackage : shs_pkg

// ### design/shs_link_if.sv
`timescale 1ns/1ps
interface shs_link_if;
  logic req;
  logic we;
  logic [15:0] index;
  logic [7:0] sub;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;
  logic err;

  modport dev (input req, input we, input index, input sub, input wdata,
               output rdata, output ack, output err);
  modport host (output req, output we, output index, output sub, output wdata,
                input rdata, input ack, input err);
endinterface : shs_link_if

// ### design/shs_device.sv
`timescale 1ns/1ps
module shs_device
  import shs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  shs_link_if.dev link,
  input wire logic limitNegPin,
  input wire logic limitPosPin,
  input wire logic homeSwitchPin,
  input wire logic indexPulsePin,
  input wire logic [31:0] positionFbk,
  output logic signed [31:0] velocityCmd,
  output logic [31:0] accelCmd,
  output logic homeSet,
  output logic [31:0] homePosition
);
  localparam int PIN_COUNT = 4;

  shs_dev_state_t state_reg, state_next;
  logic [15:0] control_reg;
  logic [7:0] modeSelect_reg;
  logic [7:0] modeDisplay_reg;
  logic [7:0] method_reg;
  logic [31:0] speedSearch_reg;
  logic [31:0] speedApproach_reg;
  logic [31:0] accel_reg;
  logic startPrev_reg;
  logic dirPos_reg, dirPos_next;
  logic reversed_reg, reversed_next;
  logic switchMet_reg, switchMet_next;
  logic attained_reg, attained_next;
  logic error_reg, error_next;
  logic homeSet_reg, homeSet_next;
  logic [31:0] homePos_reg;
  logic signed [31:0] velocity_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic err_reg;
  logic [PIN_COUNT-1:0] pinRaw, sync1_reg, sync2_reg, sync3_reg;

  // pins are asynchronous to clk_sys; stage one feeds stage two only
  assign pinRaw = {indexPulsePin, homeSwitchPin, limitPosPin, limitNegPin};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!nrst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pinRaw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  wire limNeg = sync2_reg[0];
  wire limPos = sync2_reg[1];
  wire homeSw = sync2_reg[2];
  wire indexRise = sync2_reg[3] & ~sync3_reg[3];
  wire anySwitch = limNeg | limPos | homeSw;

  // method decode
  wire isIndexBase = (method_reg >= METHOD_INDEX_FIRST) && (method_reg <= METHOD_INDEX_LAST);
  wire isLimitRef = (method_reg == METHOD_LIMIT_NEG) || (method_reg == METHOD_LIMIT_POS);
  wire isHomeRef = (method_reg >= METHOD_HOMESW_FIRST) && (method_reg <= METHOD_HOMESW_LAST);
  wire isIndexOnly = (method_reg == METHOD_INDEX_NEG) || (method_reg == METHOD_INDEX_POS);
  wire isHere = (method_reg == METHOD_HERE_A) || (method_reg == METHOD_HERE_B);
  wire isSwitchRef = isLimitRef | isHomeRef;
  wire [7:0] baseMethod = isIndexBase ? method_reg :
                          (isSwitchRef ? method_reg - METHOD_BASE_OFFSET : 8'h00);
  wire baseLimit = baseMethod <= BASE_LIMIT_LAST;
  wire baseReverse = baseMethod >= BASE_REVERSE_FIRST;
  // first direction: 1,5,6,11-14 negative; 2,3,4,7-10 positive
  wire searchDirPos = (baseMethod == 8'h02) || (baseMethod == 8'h03) ||
                      (baseMethod == 8'h04) ||
                      ((baseMethod >= 8'h07) && (baseMethod <= 8'h0a));
  // odd bases and the limit bases come back across the switch
  wire approachTurns = baseLimit | baseMethod[0];
  wire refLimit = (baseMethod == 8'h02) ? limPos : limNeg;
  wire refSwitch = baseLimit ? refLimit : homeSw;
  wire refSwitchFall = baseLimit ?
                       ((baseMethod == 8'h02) ? (~sync2_reg[1] & sync3_reg[1]) :
                                                (~sync2_reg[0] & sync3_reg[0])) :
                       (~sync2_reg[2] & sync3_reg[2]);
  wire limitAhead = dirPos_reg ? limPos : limNeg;

  wire driveEnabled = (control_reg & CW_ENABLE_MASK) == CW_ENABLE_VALUE;
  wire homingMode = modeDisplay_reg == MODE_HOMING;
  wire startRise = control_reg[CW_START_BIT] & ~startPrev_reg;
  wire motionMethod = isIndexBase | isSwitchRef | isIndexOnly;

  // sequencer
  always_comb begin
    state_next = state_reg;
    dirPos_next = dirPos_reg;
    reversed_next = reversed_reg;
    switchMet_next = switchMet_reg;
    attained_next = attained_reg;
    error_next = error_reg;
    homeSet_next = 1'b0;
    case (state_reg)
      DEV_IDLE: begin
        if (startRise && homingMode) begin
          attained_next = 1'b0;
          error_next = 1'b0;
          reversed_next = 1'b0;
          switchMet_next = 1'b0;
          if (isHere) begin
            attained_next = 1'b1;
            homeSet_next = 1'b1;
          end else if (!motionMethod) begin
            error_next = 1'b1;
          end else if (driveEnabled) begin
            if (isIndexOnly) begin
              dirPos_next = method_reg == METHOD_INDEX_POS;
              state_next = DEV_SEARCH;
            end else begin
              dirPos_next = searchDirPos;
              state_next = DEV_SEARCH;
            end
          end
        end
      end
      DEV_SEARCH: begin
        if (isIndexOnly) begin
          if (anySwitch) begin
            error_next = 1'b1;
            state_next = DEV_IDLE;
          end else if (indexRise) begin
            attained_next = 1'b1;
            homeSet_next = 1'b1;
            state_next = DEV_IDLE;
          end
        end else if (refSwitch) begin
          // switch found: turn or carry on through it at approach speed
          dirPos_next = approachTurns ? ~dirPos_reg : dirPos_reg;
          state_next = DEV_APPROACH;
        end else if (limitAhead) begin
          if (baseReverse && !reversed_reg) begin
            dirPos_next = ~dirPos_reg;
            reversed_next = 1'b1;
          end else begin
            error_next = 1'b1;
            state_next = DEV_IDLE;
          end
        end
      end
      DEV_APPROACH: begin
        if (refSwitchFall) begin
          switchMet_next = 1'b1;
        end
        if (limitAhead && !(baseLimit && refSwitch)) begin
          error_next = 1'b1;
          state_next = DEV_IDLE;
        end else if (isSwitchRef && refSwitchFall) begin
          attained_next = 1'b1;
          homeSet_next = 1'b1;
          state_next = DEV_IDLE;
        end else if (isIndexBase && switchMet_reg && indexRise) begin
          attained_next = 1'b1;
          homeSet_next = 1'b1;
          state_next = DEV_IDLE;
        end
      end
      default: begin
        state_next = DEV_IDLE;
      end
    endcase
    // bit 4 dropped or drive disabled: stop where we are
    if ((state_reg != DEV_IDLE) && (!driveEnabled || !control_reg[CW_START_BIT])) begin
      state_next = DEV_IDLE;
      homeSet_next = 1'b0;
    end
  end

  // search at speed one, approach and index-only moves at speed two
  wire [31:0] speedNow = ((state_next == DEV_SEARCH) && !isIndexOnly) ?
                         speedSearch_reg : speedApproach_reg;
  wire signed [31:0] velocityNext = (state_next == DEV_IDLE) ? 32'sh0000_0000 :
                                    (dirPos_next ? $signed(speedNow) : -$signed(speedNow));

  // register access
  wire wrReq = link.req & link.we;
  wire hitControl = (link.index == OBJ_CONTROL_WORD) && (link.sub == SUB_ZERO);
  wire hitStatus = (link.index == OBJ_STATUS_WORD) && (link.sub == SUB_ZERO);
  wire hitModeSel = (link.index == OBJ_MODE_SELECT) && (link.sub == SUB_ZERO);
  wire hitModeDisp = (link.index == OBJ_MODE_DISPLAY) && (link.sub == SUB_ZERO);
  wire hitMethod = (link.index == OBJ_HOMING_METHOD) && (link.sub == SUB_ZERO);
  wire hitSpeed1 = (link.index == OBJ_HOMING_SPEED) && (link.sub == SUB_SPEED_SEARCH);
  wire hitSpeed2 = (link.index == OBJ_HOMING_SPEED) && (link.sub == SUB_SPEED_APPROACH);
  wire hitAccel = (link.index == OBJ_HOMING_ACCEL) && (link.sub == SUB_ZERO);
  wire hitWritable = hitControl | hitModeSel | hitMethod | hitSpeed1 | hitSpeed2 | hitAccel;
  wire hitAny = hitWritable | hitStatus | hitModeDisp;
  wire accessBad = link.we ? ~hitWritable : ~hitAny;
  // homing parameters are frozen while a move runs
  wire paramLock = state_reg != DEV_IDLE;

  wire [15:0] statusWord = (16'h0001 << SW_ERROR_BIT) & {16{error_reg}} |
                           (16'h0001 << SW_ATTAINED_BIT) & {16{attained_reg}} |
                           (16'h0001 << SW_REACHED_BIT) &
                             {16{(state_reg == DEV_IDLE) & (attained_reg | error_reg)}} |
                           (16'h0001 << SW_ENABLED_BIT) & {16{driveEnabled}};
  wire [31:0] readMux = hitControl ? {16'h0000, control_reg} :
                        hitStatus ? {16'h0000, statusWord} :
                        hitModeSel ? {24'h00_0000, modeSelect_reg} :
                        hitModeDisp ? {24'h00_0000, modeDisplay_reg} :
                        hitMethod ? {24'h00_0000, method_reg} :
                        hitSpeed1 ? speedSearch_reg :
                        hitSpeed2 ? speedApproach_reg :
                        hitAccel ? accel_reg : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      control_reg <= CW_RESET;
      modeSelect_reg <= MODE_RESET;
      modeDisplay_reg <= MODE_RESET;
      method_reg <= METHOD_RESET;
      speedSearch_reg <= SPEED_RESET;
      speedApproach_reg <= SPEED_RESET;
      accel_reg <= ACCEL_RESET;
    end else begin
      if (wrReq && hitControl) control_reg <= link.wdata[15:0];
      if (wrReq && hitModeSel) modeSelect_reg <= link.wdata[7:0];
      if (wrReq && hitMethod && !paramLock) method_reg <= link.wdata[7:0];
      if (wrReq && hitSpeed1 && !paramLock) speedSearch_reg <= link.wdata;
      if (wrReq && hitSpeed2 && !paramLock) speedApproach_reg <= link.wdata;
      if (wrReq && hitAccel && !paramLock) accel_reg <= link.wdata;
      modeDisplay_reg <= modeSelect_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= link.req;
      err_reg <= link.req & accessBad;
      rdata_reg <= link.req ? readMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= DEV_IDLE;
      startPrev_reg <= 1'b0;
      dirPos_reg <= 1'b0;
      reversed_reg <= 1'b0;
      switchMet_reg <= 1'b0;
      attained_reg <= 1'b0;
      error_reg <= 1'b0;
      homeSet_reg <= 1'b0;
      homePos_reg <= 32'h0000_0000;
      velocity_reg <= 32'sh0000_0000;
    end else begin
      state_reg <= state_next;
      startPrev_reg <= control_reg[CW_START_BIT];
      dirPos_reg <= dirPos_next;
      reversed_reg <= reversed_next;
      switchMet_reg <= switchMet_next;
      attained_reg <= attained_next;
      error_reg <= error_next;
      homeSet_reg <= homeSet_next;
      if (homeSet_next) homePos_reg <= positionFbk;
      velocity_reg <= velocityNext;
    end
  end

  assign link.ack = ack_reg;
  assign link.err = err_reg;
  assign link.rdata = rdata_reg;
  assign velocityCmd = velocity_reg;
  assign accelCmd = accel_reg;
  assign homeSet = homeSet_reg;
  assign homePosition = homePos_reg;
endmodule : shs_device

// ### design/shs_host.sv
`timescale 1ns/1ps
module shs_host
  import shs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  shs_link_if.host link,
  input wire logic cmdStart,
  input wire logic [7:0] cmdMethod,
  input wire logic [31:0] cmdSpeedSearch,
  input wire logic [31:0] cmdSpeedApproach,
  input wire logic [31:0] cmdAccel,
  output logic busy,
  output logic done,
  output logic failed,
  output logic [15:0] lastStatus
);
  localparam logic [3:0] STEP_MODE = 4'h0;
  localparam logic [3:0] STEP_CONFIRM = 4'h1;
  localparam logic [3:0] STEP_ENABLE = 4'h6;
  localparam logic [3:0] STEP_POLL = 4'h8;
  localparam logic [3:0] STEP_LAST = 4'h9;

  shs_host_state_t state_reg;
  logic [3:0] step_reg;
  logic [7:0] method_reg;
  logic [31:0] speed1_reg, speed2_reg, accel_reg;
  logic done_reg, failed_reg;
  logic [15:0] status_reg;
  logic stepWe;
  logic [15:0] stepIndex;
  logic [7:0] stepSub;
  logic [31:0] stepData;

  // one access per step; confirm and poll steps repeat until satisfied
  always_comb begin
    stepWe = 1'b1;
    stepIndex = OBJ_CONTROL_WORD;
    stepSub = SUB_ZERO;
    stepData = 32'h0000_0000;
    case (step_reg)
      4'h0: begin
        stepIndex = OBJ_MODE_SELECT;
        stepData = {24'h00_0000, MODE_HOMING};
      end
      4'h1: begin
        stepWe = 1'b0;
        stepIndex = OBJ_MODE_DISPLAY;
      end
      4'h2: begin
        stepIndex = OBJ_HOMING_METHOD;
        stepData = {24'h00_0000, method_reg};
      end
      4'h3: begin
        stepIndex = OBJ_HOMING_SPEED;
        stepSub = SUB_SPEED_SEARCH;
        stepData = speed1_reg;
      end
      4'h4: begin
        stepIndex = OBJ_HOMING_SPEED;
        stepSub = SUB_SPEED_APPROACH;
        stepData = speed2_reg;
      end
      4'h5: begin
        stepIndex = OBJ_HOMING_ACCEL;
        stepData = accel_reg;
      end
      4'h6: stepData = {16'h0000, CW_ENABLE_VALUE};
      // enable alone first, so bit 4 is seen rising
      4'h7: stepData = {16'h0000, CW_START_VALUE};
      4'h8: begin
        stepWe = 1'b0;
        stepIndex = OBJ_STATUS_WORD;
      end
      default: stepData = {16'h0000, CW_ENABLE_VALUE};
    endcase
  end

  wire modeOk = link.rdata[7:0] == MODE_HOMING;
  wire homingOver = link.rdata[SW_ATTAINED_BIT] | link.rdata[SW_ERROR_BIT];
  wire stepRepeat = ((step_reg == STEP_CONFIRM) && !modeOk) ||
                    ((step_reg == STEP_POLL) && !homingOver);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= HOST_IDLE;
      step_reg <= STEP_MODE;
      method_reg <= METHOD_RESET;
      speed1_reg <= SPEED_RESET;
      speed2_reg <= SPEED_RESET;
      accel_reg <= ACCEL_RESET;
      done_reg <= 1'b0;
      failed_reg <= 1'b0;
      status_reg <= 16'h0000;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        HOST_IDLE: begin
          if (cmdStart) begin
            method_reg <= cmdMethod;
            speed1_reg <= cmdSpeedSearch;
            speed2_reg <= cmdSpeedApproach;
            accel_reg <= cmdAccel;
            step_reg <= STEP_MODE;
            failed_reg <= 1'b0;
            state_reg <= HOST_REQ;
          end
        end
        HOST_REQ: state_reg <= HOST_WAIT;
        HOST_WAIT: begin
          if (link.ack) begin
            if (step_reg == STEP_POLL) status_reg <= link.rdata[15:0];
            if (link.err) failed_reg <= 1'b1;
            if (step_reg == STEP_POLL && homingOver) failed_reg <= link.rdata[SW_ERROR_BIT];
            if (step_reg == STEP_LAST) begin
              done_reg <= 1'b1;
              state_reg <= HOST_IDLE;
            end else begin
              // parameters precede the enable and start steps
              step_reg <= stepRepeat ? step_reg : step_reg + 4'h1;
              state_reg <= HOST_REQ;
            end
          end
        end
        default: state_reg <= HOST_IDLE;
      endcase
    end
  end

  assign link.req = state_reg == HOST_REQ;
  assign link.we = stepWe;
  assign link.index = stepIndex;
  assign link.sub = stepSub;
  assign link.wdata = stepData;
  assign busy = state_reg != HOST_IDLE;
  assign done = done_reg;
  assign failed = failed_reg;
  assign lastStatus = status_reg;
endmodule : shs_host

// ### sim/shs_monitor.sv
`timescale 1ns/1ps
module shs_monitor
  import shs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] index,
  input wire logic [7:0] sub,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack,
  input wire logic err
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic [15:0] lastCwReg;
  logic [3:0] paramsReg;
  wire cwWrite = req && we && (index == OBJ_CONTROL_WORD);
  wire startWrite = cwWrite && wdata[CW_START_BIT];

  // parameter writes are remembered until reset, so only the first start is strict
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lastCwReg <= CW_RESET;
      paramsReg <= 4'h0;
    end else if (req && we) begin
      if (index == OBJ_CONTROL_WORD) lastCwReg <= wdata[15:0];
      if (index == OBJ_HOMING_METHOD) paramsReg[0] <= 1'b1;
      if (index == OBJ_HOMING_SPEED && sub == SUB_SPEED_SEARCH) paramsReg[1] <= 1'b1;
      if (index == OBJ_HOMING_SPEED && sub == SUB_SPEED_APPROACH) paramsReg[2] <= 1'b1;
      if (index == OBJ_HOMING_ACCEL) paramsReg[3] <= 1'b1;
    end
  end

  AST_ACK_AFTER_REQ: assert property (req |=> ack)
    else $error("ack missing one cycle after request");
  AST_NO_STRAY_ACK: assert property (!req |=> !ack)
    else $error("ack without request");
  AST_ERR_WITH_ACK: assert property (err |-> ack)
    else $error("err outside ack");
  AST_RDATA_IDLE_ZERO: assert property (!ack |-> rdata == 32'h0)
    else $error("read data not zero outside ack");
  AST_MODE_SIX: assert property (req && we && index == OBJ_MODE_SELECT |-> wdata == 32'h6)
    else $error("mode select written with other than homing");
  AST_DISPLAY_SIX: assert property (
    $past(req && !we && index == OBJ_MODE_DISPLAY) && ack |-> rdata == 32'h6 && !err)
    else $error("mode display not homing after select");
  AST_PARAMS_FIRST: assert property (startWrite |-> paramsReg == 4'hf)
    else $error("start before all homing parameters written");
  AST_PARAM_WRITE_OK: assert property (
    req && we && index == OBJ_HOMING_SPEED |=> ack && !err)
    else $error("speed write refused");
  AST_START_EDGE: assert property (
    startWrite |-> !lastCwReg[CW_START_BIT] && lastCwReg[3:0] == 4'hf)
    else $error("start bit not a rise after enable");
  AST_SPEED_SUBS: assert property (
    req && index == OBJ_HOMING_SPEED |-> sub == SUB_SPEED_SEARCH || sub == SUB_SPEED_APPROACH)
    else $error("speed object with bad subindex");
endmodule : shs_monitor

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  import shs_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cmdStart = 1'b0;
  logic [7:0] cmdMethod = 8'h00;
  logic [31:0] cmdSpeedSearch = 32'h0;
  logic [31:0] cmdSpeedApproach = 32'h0;
  logic [31:0] cmdAccel = 32'h0;
  logic [3:0] pins = 4'h0;
  logic [31:0] positionFbk = 32'h0;
  logic signed [31:0] velocityCmd;
  logic [31:0] accelCmd, homePosition, s1, s2;
  logic homeSet, busy, done, failed;
  logic [15:0] lastStatus;
  int errTotal = 0;
  int compares = 0;
  int seed = 80648;
  int homeCnt = 0;
  int moveCnt = 0;
  int h0, m0;

  shs_link_if link();
  shs_device u_shs_device (.clk_sys(clk_sys), .nrst(nrst), .link(link.dev),
    .limitNegPin(pins[0]), .limitPosPin(pins[1]), .homeSwitchPin(pins[2]),
    .indexPulsePin(pins[3]), .positionFbk(positionFbk), .velocityCmd(velocityCmd),
    .accelCmd(accelCmd), .homeSet(homeSet), .homePosition(homePosition));
  shs_host u_shs_host (.clk_sys(clk_sys), .nrst(nrst), .link(link.host), .cmdStart(cmdStart),
    .cmdMethod(cmdMethod), .cmdSpeedSearch(cmdSpeedSearch),
    .cmdSpeedApproach(cmdSpeedApproach), .cmdAccel(cmdAccel), .busy(busy), .done(done),
    .failed(failed), .lastStatus(lastStatus));
  shs_monitor u_shs_monitor (.clk_sys(clk_sys), .nrst(nrst), .req(link.req), .we(link.we),
    .index(link.index), .sub(link.sub), .wdata(link.wdata), .rdata(link.rdata),
    .ack(link.ack), .err(link.err));

  initial forever #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (homeSet === 1'b1) homeCnt++;
    if (velocityCmd !== 32'sh0) moveCnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic testDone;
    $display("compares=%0d mismatches=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : testDone

  task automatic waitVel(input logic [31:0] v);
    int n;
    n = 0;
    while (velocityCmd === v && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n < 300), 32'h1);
  endtask : waitVel

  task automatic waitDone;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n < 2000), 32'h1);
  endtask : waitDone

  task automatic start(input logic [7:0] m);
    @(negedge clk_sys);
    s1 = ($random(seed) & 32'hffff) | 32'h1;
    s2 = ($random(seed) & 32'hffff) | 32'h1;
    positionFbk = $random(seed);
    cmdMethod = m;
    cmdSpeedSearch = s1;
    cmdSpeedApproach = s2;
    cmdAccel = $random(seed);
    cmdStart = 1'b1;
    h0 = homeCnt;
    m0 = moveCnt;
    @(negedge clk_sys);
    cmdStart = 1'b0;
  endtask : start

  // expected direction: true means negative first move
  function automatic logic negFirst(input logic [7:0] m);
    logic [7:0] b;
    b = (m >= METHOD_LIMIT_NEG) ? m - METHOD_BASE_OFFSET : m;
    return (m == METHOD_INDEX_NEG) || (m < METHOD_INDEX_NEG && b inside {1, 5, 6, 11, 12, 13, 14});
  endfunction : negFirst

  function automatic logic turns(input logic [7:0] m);
    logic [7:0] b;
    b = (m >= METHOD_LIMIT_NEG) ? m - METHOD_BASE_OFFSET : m;
    return b[0] || b == 8'h02;
  endfunction : turns

  task automatic run(input logic [7:0] m, input int refBit, input bit useIdx);
    start(m);
    if (m == METHOD_HERE_A || m == METHOD_HERE_B) begin
      waitDone;
      check(32'(moveCnt - m0), 32'h0);
    end else begin
      waitVel(32'h0);
      if (m >= METHOD_INDEX_NEG) begin
        check(velocityCmd, negFirst(m) ? -s2 : s2);
      end else begin
        check(velocityCmd, negFirst(m) ? -s1 : s1);
        pins[refBit] = 1'b1;
        waitVel(velocityCmd);
        check(velocityCmd, (negFirst(m) ^ turns(m)) ? -s2 : s2);
        pins[refBit] = 1'b0;
        if (useIdx) begin
          repeat (8) @(negedge clk_sys);
          check(32'(homeCnt - h0), 32'h0);
        end
      end
      if (useIdx) begin
        pins[3] = 1'b1;
        repeat (3) @(negedge clk_sys);
        pins[3] = 1'b0;
      end
      waitDone;
    end
    check(32'(homeCnt - h0), 32'h1);
    check(homePosition, positionFbk);
    check(32'(failed), 32'h0);
    check(32'(lastStatus[SW_ATTAINED_BIT]), 32'h1);
    check(velocityCmd, 32'h0);
    check(accelCmd, cmdAccel);
    check(32'(lastStatus[SW_ENABLED_BIT]), 32'h1);
    check(32'(busy), 32'h0);
  endtask : run

  task automatic errRun(input logic [7:0] m, input int bitNo, input bit mv);
    start(m);
    if (mv) begin
      waitVel(32'h0);
      pins[bitNo] = 1'b1;
    end
    waitDone;
    pins[bitNo] = 1'b0;
    check(32'(failed), 32'h1);
    check(32'(lastStatus[SW_ERROR_BIT]), 32'h1);
    check(32'(lastStatus[SW_ATTAINED_BIT]), 32'h0);
    check(velocityCmd, 32'h0);
    check(32'(homeCnt - h0), 32'h0);
  endtask : errRun

  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    run(METHOD_HERE_A, 0, 1'b0);
    run(METHOD_HERE_B, 0, 1'b0);
    run(METHOD_INDEX_NEG, 0, 1'b1);
    run(METHOD_INDEX_POS, 0, 1'b1);
    run(METHOD_LIMIT_NEG, 0, 1'b0);
    run(METHOD_LIMIT_POS, 1, 1'b0);
    run(8'h03, 2, 1'b1);
    run(METHOD_HOMESW_FIRST, 2, 1'b0);
    run(METHOD_HOMESW_LAST, 2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run(8'h14 + 8'(($random(seed) & 32'h7fffffff) % 10), 2, 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      errRun(i == 1 ? METHOD_INDEX_POS : METHOD_INDEX_NEG, i, 1'b1);
    end
    errRun(8'h0f, 0, 1'b0);
    testDone;
  end

  // whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #200000;
    errTotal++;
    testDone;
  end
endmodule : tb
